// ---- shared/pdtac_cfg.svh ----
// What this block does
// - with no busy option set, a busy line abandons the packet and its retries
// - retry bit makes a busy line re-attempt up to the limit, then report failure
// - hard reset, or enabled cable reset on a cable packet, still aborts
// - good new non-Ping non-GoodCRC receive of matching type aborts the packet
// - software abort bit cancels a pending packet whatever the busy options
// - received primary packet aborts a pending non-primary one unless kept
// - busy line never drops the Soft Reset acknowledge unless special case disabled
// - with special case disabled, hold-until-quiet also governs that acknowledge
// - hold bit waits for a quiet line, and wins over the retry bit
// - auto-response bit enables hardware GoodCRC and BIST answers
// - auto-response off means no hardware retries, limit ignored
// - queue-mode bit picks buffer addressing or FIFO pushes for queue writes
// - raw bit picks raw data path, automatic path by default
// - control register is 8 bits at its offset, bit 7 reads zero, resets zero
// - retry limit sits in bits 6:4, zero disables hardware retry
// - automatic path uses queued length to place the CRC
`ifndef PDTAC_CFG_SVH
`define PDTAC_CFG_SVH
// register offsets
`define PDTAC_A_CTL 16'h1a00
`define PDTAC_A_STAT 16'h1a01
`define PDTAC_A_PARC 16'h1a02
`define PDTAC_A_LEN 16'h1a03
`define PDTAC_A_CTLB 16'h1a04
`define PDTAC_A_QUEUE 16'h1b00
`define PDTAC_Q_MASK 16'hffe0
`define PDTAC_Q_IDX 4:0
// write masks and reset value
`define PDTAC_CTL_MASK 8'h7f
`define PDTAC_PARC_MASK 8'hfc
`define PDTAC_LEN_MASK 8'h3f
`define PDTAC_REG_RST 8'h00
// control bit positions
`define PDTAC_B_RETRY 6
`define PDTAC_B_KEEP 5
`define PDTAC_B_NOSR 4
`define PDTAC_B_HOLD 3
`define PDTAC_B_AUTO 2
`define PDTAC_B_FMQ 1
`define PDTAC_B_RAW 0
`define PDTAC_B_GO 0
`define PDTAC_B_ABORT 1
// fields
`define PDTAC_F_RCNT 6:4
`define PDTAC_F_LEN 5:0
// start-of-packet type codes
`define PDTAC_SOP 3'h0
`define PDTAC_SOPP 3'h1
`define PDTAC_SOPPP 3'h2
`define PDTAC_SOPP_DBG 3'h3
`define PDTAC_SOPPP_DBG 3'h4
// queue geometry
`define PDTAC_DW 8
`define PDTAC_DEPTH 32
`endif

// ---- shared/pdtac_pkg.sv ----
`include "pdtac_cfg.svh"
package pdtac_pkg;
    typedef enum logic [1:0] {S_IDLE, S_TRY, S_SEND, S_WACK} pdtac_st_e;
    typedef struct packed {
        pdtac_st_e st;
        logic [7:0] ctl;
        logic [7:0] parc;
        logic [7:0] len;
        logic [7:0] rdata;
        logic abort_req;
        logic [2:0] tries;
        logic [2:0] lim;
        logic [2:0] tx_sop;
        logic [4:0] wptr;
        logic [5:0] ld;
        logic [5:0] ocnt;
        logic ovalid;
        logic [7:0] odata;
        logic olast;
        logic ocrc;
        logic active;
        logic done;
        logic aborted;
        logic failed;
        logic ack_pend;
        logic ack_sr;
        logic ack_bist;
        logic resp_send;
        logic resp_bist;
        logic resp_drop;
        logic [`PDTAC_DEPTH-1:0][`PDTAC_DW-1:0] buffer;
    } pdtac_s;
endpackage : pdtac_pkg

// ---- src/pdtac_top.sv ----
`timescale 1ns/1ns
`include "pdtac_cfg.svh"

// ----------------------------------------------------------------
// transmit byte queue
// ----------------------------------------------------------------
module pdtac_fifo #(
    parameter int W = `PDTAC_DW,
    parameter int D = `PDTAC_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } pdtac_fifo_s;
    pdtac_fifo_s f;
    pdtac_fifo_s next_f;
    logic push;
    logic pop;

    // flags come from the held count, so full and empty are exact
    assign in_ready_o = f.cnt != (AW+1)'(D);
    assign out_valid_o = f.cnt != '0;
    assign out_data_o = f.mem[f.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and count update, flush wins over traffic
    always_comb begin
        next_f = f;
        if (push) begin
            next_f.mem[f.wp] = in_data_i;
            next_f.wp = f.wp + 1'b1;
        end
        if (pop) begin
            next_f.rp = f.rp + 1'b1;
        end
        next_f.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            next_f.wp = '0;
            next_f.rp = '0;
            next_f.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end
endmodule : pdtac_fifo

// ----------------------------------------------------------------
// transmit abort and retry control
// ----------------------------------------------------------------
module pdtac_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // register port
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    output logic [7:0] REG_RDATA_O,
    // line state and receive events
    input wire logic LINE_BUSY_I,
    input wire logic RX_GOOD_I,
    input wire logic [2:0] RX_SOP_I,
    input wire logic RX_DUP_I,
    input wire logic RX_PING_I,
    input wire logic RX_GCRC_I,
    input wire logic RX_HARDRST_I,
    input wire logic RX_CABLERST_I,
    input wire logic CABLE_RST_EN_I,
    // packet type for the next start
    input wire logic [2:0] TX_SOP_I,
    // auto-response requests
    input wire logic GCRC_REQ_I,
    input wire logic GCRC_SR_I,
    input wire logic BIST_REQ_I,
    // partner acknowledge
    input wire logic ACK_OK_I,
    input wire logic ACK_TIMEOUT_I,
    // byte stream to the encoder
    output logic PHY_VALID_O,
    output logic [7:0] PHY_DATA_O,
    output logic PHY_LAST_O,
    output logic PHY_CRC_O,
    input wire logic PHY_READY_I,
    // auto-response outcome
    output logic RESP_SEND_O,
    output logic RESP_BIST_O,
    output logic RESP_DROP_O,
    // transmit outcome
    output logic TX_ACTIVE_O,
    output logic TX_DONE_O,
    output logic TX_ABORTED_O,
    output logic TRANSMIT_FAILED_FLAG_O
);
    pdtac_pkg::pdtac_s s;
    pdtac_pkg::pdtac_s next_s;
    logic pending;
    logic busy_kill;
    logic cable_kill;
    logic rx_kill;
    logic kill;
    logic go;
    logic sw_abort;
    logic qwr;
    logic special;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic f_pop;
    logic [7:0] f_out_data;

    // ----------------------------------------------------------------
    // abort causes
    // ----------------------------------------------------------------
    assign pending = s.st != pdtac_pkg::S_IDLE;
    assign cable_kill = RX_CABLERST_I && CABLE_RST_EN_I && (s.tx_sop inside
        {`PDTAC_SOPP, `PDTAC_SOPPP, `PDTAC_SOPP_DBG, `PDTAC_SOPPP_DBG});
    // matching type, or primary receive over a non-primary packet
    assign rx_kill = RX_GOOD_I && !RX_DUP_I && !RX_PING_I && !RX_GCRC_I
        && ((RX_SOP_I == s.tx_sop)
        || (RX_SOP_I == `PDTAC_SOP && s.tx_sop != `PDTAC_SOP
        && !s.ctl[`PDTAC_B_KEEP]));
    assign busy_kill = s.abort_req || RX_HARDRST_I || cable_kill || rx_kill;
    assign kill = pending && busy_kill;

    // register strobes decoded straight from the port
    assign go = REG_WR_I && REG_ADDR_I == `PDTAC_A_CTLB && REG_WDATA_I[`PDTAC_B_GO];
    assign sw_abort = REG_WR_I && REG_ADDR_I == `PDTAC_A_CTLB
        && REG_WDATA_I[`PDTAC_B_ABORT];
    assign qwr = REG_WR_I && (REG_ADDR_I & `PDTAC_Q_MASK) == `PDTAC_A_QUEUE;
    assign special = s.ack_sr && !s.ctl[`PDTAC_B_NOSR];

    // loader feeds the queue, output stage drains it
    assign f_in_valid = s.st == pdtac_pkg::S_SEND && s.ld != s.len[`PDTAC_F_LEN];
    assign f_pop = f_out_valid && (!s.ovalid || PHY_READY_I);

    pdtac_fifo #(
        .W(`PDTAC_DW),
        .D(`PDTAC_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .flush_i(kill),
        .in_valid_i(f_in_valid),
        .in_ready_o(f_in_ready),
        .in_data_i(s.buffer[s.ld[`PDTAC_Q_IDX]]),
        .out_valid_o(f_out_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_out_data)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.aborted = 1'b0;
        next_s.failed = 1'b0;
        next_s.resp_send = 1'b0;
        next_s.resp_bist = 1'b0;
        next_s.resp_drop = 1'b0;
        // control writes, bit 7 kept zero
        if (REG_WR_I && REG_ADDR_I == `PDTAC_A_CTL) begin
            next_s.ctl = REG_WDATA_I & `PDTAC_CTL_MASK;
        end
        if (REG_WR_I && REG_ADDR_I == `PDTAC_A_PARC) begin
            next_s.parc = REG_WDATA_I & `PDTAC_PARC_MASK;
        end
        if (REG_WR_I && REG_ADDR_I == `PDTAC_A_LEN) begin
            next_s.len = REG_WDATA_I & `PDTAC_LEN_MASK;
        end
        // queue writes: fifo mode appends, buffer mode addresses by offset
        if (qwr) begin
            if (s.ctl[`PDTAC_B_FMQ]) begin
                next_s.buffer[s.wptr] = REG_WDATA_I;
                next_s.wptr = s.wptr + 5'h1;
            end else begin
                next_s.buffer[REG_ADDR_I[`PDTAC_Q_IDX]] = REG_WDATA_I;
            end
        end
        // read data is registered, unmapped offsets read zero
        unique case (REG_ADDR_I)
            `PDTAC_A_CTL: next_s.rdata = s.ctl;
            `PDTAC_A_STAT: next_s.rdata = {1'b0, s.tries, 3'h0, s.active};
            `PDTAC_A_PARC: next_s.rdata = s.parc;
            `PDTAC_A_LEN: next_s.rdata = s.len;
            default: next_s.rdata = `PDTAC_REG_RST;
        endcase
        // transmit sequence
        unique case (s.st)
            pdtac_pkg::S_IDLE: begin
                if (go) begin
                    next_s.tries = 3'h0;
                    // limit frozen at start so one packet sees one policy
                    next_s.lim = s.ctl[`PDTAC_B_AUTO] ? s.parc[`PDTAC_F_RCNT] : 3'h0;
                    next_s.tx_sop = TX_SOP_I;
                    next_s.wptr = 5'h0;
                    next_s.st = pdtac_pkg::S_TRY;
                end
            end
            pdtac_pkg::S_TRY: begin
                if (!LINE_BUSY_I) begin
                    // a pending acknowledge takes the quiet line first
                    if (!s.ack_pend) begin
                        next_s.ld = 6'h0;
                        next_s.ocnt = 6'h0;
                        next_s.st = pdtac_pkg::S_SEND;
                    end
                end else if (s.ctl[`PDTAC_B_HOLD]) begin
                    next_s.st = pdtac_pkg::S_TRY;
                end else if (s.ctl[`PDTAC_B_RETRY] && s.tries < s.lim) begin
                    next_s.tries = s.tries + 3'h1;
                end else if (s.ctl[`PDTAC_B_RETRY]) begin
                    next_s.failed = 1'b1;
                    next_s.st = pdtac_pkg::S_IDLE;
                end else begin
                    next_s.aborted = 1'b1;
                    next_s.st = pdtac_pkg::S_IDLE;
                end
            end
            pdtac_pkg::S_SEND: begin
                if (f_in_valid && f_in_ready) begin
                    next_s.ld = s.ld + 6'h1;
                end
                if (!f_in_valid && !f_out_valid && !s.ovalid) begin
                    if (s.ctl[`PDTAC_B_AUTO]) begin
                        next_s.st = pdtac_pkg::S_WACK;
                    end else begin
                        next_s.done = 1'b1;
                        next_s.st = pdtac_pkg::S_IDLE;
                    end
                end
            end
            pdtac_pkg::S_WACK: begin
                if (ACK_OK_I) begin
                    next_s.done = 1'b1;
                    next_s.st = pdtac_pkg::S_IDLE;
                end else if (ACK_TIMEOUT_I && s.tries < s.lim) begin
                    next_s.tries = s.tries + 3'h1;
                    next_s.st = pdtac_pkg::S_TRY;
                end else if (ACK_TIMEOUT_I) begin
                    next_s.failed = 1'b1;
                    next_s.st = pdtac_pkg::S_IDLE;
                end
            end
        endcase
        // output stage; crc mark only on the automatic path
        if (f_pop) begin
            next_s.ovalid = 1'b1;
            next_s.odata = f_out_data;
            next_s.ocnt = s.ocnt + 6'h1;
            next_s.olast = (s.ocnt + 6'h1) == s.len[`PDTAC_F_LEN];
            next_s.ocrc = next_s.olast && !s.ctl[`PDTAC_B_RAW];
        end else if (PHY_READY_I) begin
            next_s.ovalid = 1'b0;
            next_s.olast = 1'b0;
            next_s.ocrc = 1'b0;
        end
        // abort causes override every busy option
        if (kill) begin
            next_s.st = pdtac_pkg::S_IDLE;
            next_s.aborted = 1'b1;
            next_s.done = 1'b0;
            next_s.failed = 1'b0;
            next_s.ovalid = 1'b0;
            next_s.olast = 1'b0;
            next_s.ocrc = 1'b0;
        end
        // abort request: clear when consumed, a fresh write wins
        if (kill || !pending) begin
            next_s.abort_req = 1'b0;
        end
        if (sw_abort && pending) begin
            next_s.abort_req = 1'b1;
        end
        // acknowledge service, never while a packet is on the line
        if (s.ack_pend && s.st != pdtac_pkg::S_SEND) begin
            if (!LINE_BUSY_I) begin
                next_s.resp_send = 1'b1;
                next_s.resp_bist = s.ack_bist;
                next_s.ack_pend = 1'b0;
            end else if (!special && !s.ctl[`PDTAC_B_HOLD]) begin
                next_s.resp_drop = 1'b1;
                next_s.ack_pend = 1'b0;
            end
        end
        // new requests only with auto-response, set wins over service
        if (s.ctl[`PDTAC_B_AUTO] && (GCRC_REQ_I || BIST_REQ_I)) begin
            next_s.ack_pend = 1'b1;
            next_s.ack_sr = GCRC_REQ_I && GCRC_SR_I;
            next_s.ack_bist = BIST_REQ_I;
        end
        next_s.active = next_s.st != pdtac_pkg::S_IDLE;
    end

    // state register, everything resets to zero
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign REG_RDATA_O = s.rdata;
    assign PHY_VALID_O = s.ovalid;
    assign PHY_DATA_O = s.odata;
    assign PHY_LAST_O = s.olast;
    assign PHY_CRC_O = s.ocrc;
    assign RESP_SEND_O = s.resp_send;
    assign RESP_BIST_O = s.resp_bist;
    assign RESP_DROP_O = s.resp_drop;
    assign TX_ACTIVE_O = s.active;
    assign TX_DONE_O = s.done;
    assign TX_ABORTED_O = s.aborted;
    assign TRANSMIT_FAILED_FLAG_O = s.failed;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence seq_busy_try;
        s.st == pdtac_pkg::S_TRY && LINE_BUSY_I && !busy_kill;
    endsequence
    sequence seq_abort_write;
        sw_abort && pending;
    endsequence

    a_plain_busy_abort: assert property (seq_busy_try and !s.ctl[`PDTAC_B_HOLD]
        && !s.ctl[`PDTAC_B_RETRY] |=> s.aborted && !s.active)
        else $error("busy line did not abort");
    a_retry_exhaust: assert property (seq_busy_try and s.ctl[`PDTAC_B_RETRY]
        && !s.ctl[`PDTAC_B_HOLD] && s.tries >= s.lim |=> s.failed && !s.aborted)
        else $error("exhausted retries did not fail");
    a_hard_reset_kill: assert property (pending && RX_HARDRST_I
        |=> s.aborted && s.st == pdtac_pkg::S_IDLE)
        else $error("hard reset did not abort");
    a_rx_kill: assert property (pending && rx_kill |=> s.aborted)
        else $error("receive did not abort");
    a_sw_abort: assert property (seq_abort_write |-> ##[1:2] s.aborted)
        else $error("software abort ignored");
    a_keep_secondary: assert property (pending && s.ctl[`PDTAC_B_KEEP]
        && s.tx_sop != `PDTAC_SOP && RX_SOP_I == `PDTAC_SOP && !s.abort_req
        && !RX_HARDRST_I && !cable_kill |-> !kill)
        else $error("primary receive aborted a kept packet");
    a_special_ack: assert property (s.ack_pend && special && LINE_BUSY_I
        |=> s.ack_pend && !s.resp_drop)
        else $error("soft reset acknowledge dropped");
    a_hold_wait: assert property (seq_busy_try and s.ctl[`PDTAC_B_HOLD]
        |=> s.st == pdtac_pkg::S_TRY && !s.failed && !s.aborted)
        else $error("hold bit did not wait");
    a_auto_gate: assert property ($rose(s.ack_pend) |-> $past(s.ctl[`PDTAC_B_AUTO]))
        else $error("acknowledge queued without auto-response");
    a_no_auto_retry: assert property (go && !pending && !s.ctl[`PDTAC_B_AUTO]
        |=> s.lim == 3'h0)
        else $error("retry limit kept with auto-response off");
    a_crc_mark: assert property (s.ocrc |-> s.olast && !s.ctl[`PDTAC_B_RAW])
        else $error("crc marked on raw path");
endmodule : pdtac_top

// ---- dv/pdtac_partner.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------
// far-side byte sink and acknowledger
// ----------------------------------------------------------------
module pdtac_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // byte stream from the framer
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic last_i,
    output logic ready_o,
    // acknowledge behaviour
    input wire logic ack_en_i,
    output logic ack_ok_o,
    output logic ack_to_o,
    // summary of the last whole frame
    output logic [5:0] cnt_o,
    output logic [7:0] xsum_o
);
    logic [5:0] n;
    logic [7:0] xs;
    logic [1:0] ack_dly;

    // stall every other cycle so the queue has to hold bytes back
    always @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            ack_dly <= 2'h0;
            n <= 6'h00;
            xs <= 8'h00;
            cnt_o <= 6'h00;
            xsum_o <= 8'h00;
        end else begin
            ready_o <= ~ready_o;
            ack_dly <= {ack_dly[0], valid_i & ready_o & last_i};
            if (valid_i && ready_o) begin
                n <= last_i ? 6'h00 : n + 6'h01;
                xs <= last_i ? 8'h00 : xs ^ data_i;
                if (last_i) begin
                    cnt_o <= n + 6'h01;
                    xsum_o <= xs ^ data_i;
                end
            end
        end
    end
    // answer lands two cycles after the last byte; a silent partner stands in for the timer
    assign ack_ok_o = ack_dly[1] & ack_en_i;
    assign ack_to_o = ack_dly[1] & ~ack_en_i;
endmodule : pdtac_partner

// ---- dv/pdtac_top_test.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------
// self-checking bench for the abort and retry control
// ----------------------------------------------------------------
module pdtac_top_test;
    logic clk, rst, wr, busy, rx_good, hard, cable, cable_en, gcrc, gsr, bist;
    logic rx_dup, rx_ping, rx_gcrc, ack_to;
    logic ack_en, ack_ok, pv, pl, pc, pr, rs, rb, rd_, txa, done, abrt, fail;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, pd, xsum, exp_x;
    logic [2:0] rx_sop, tx_sop;
    logic [5:0] cnt, exp_n;
    logic [7:0] ctl;
    logic [5:0] ev;
    logic [5:0] expq[$];
    int n_fail, total_checks, seed, cyc;

    pdtac_top dut_u (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RDATA_O(rdata), .LINE_BUSY_I(busy), .RX_GOOD_I(rx_good),
        .RX_SOP_I(rx_sop), .RX_DUP_I(rx_dup), .RX_PING_I(rx_ping), .RX_GCRC_I(rx_gcrc),
        .RX_HARDRST_I(hard), .RX_CABLERST_I(cable), .CABLE_RST_EN_I(cable_en),
        .TX_SOP_I(tx_sop), .GCRC_REQ_I(gcrc), .GCRC_SR_I(gsr), .BIST_REQ_I(bist),
        .ACK_OK_I(ack_ok), .ACK_TIMEOUT_I(ack_to), .PHY_VALID_O(pv), .PHY_DATA_O(pd),
        .PHY_LAST_O(pl), .PHY_CRC_O(pc), .PHY_READY_I(pr), .RESP_SEND_O(rs),
        .RESP_BIST_O(rb), .RESP_DROP_O(rd_), .TX_ACTIVE_O(txa), .TX_DONE_O(done),
        .TX_ABORTED_O(abrt), .TRANSMIT_FAILED_FLAG_O(fail));
    pdtac_partner far_u (.clk_i(clk), .rst_i(rst), .valid_i(pv), .data_i(pd), .last_i(pl),
        .ready_o(pr), .ack_en_i(ack_en), .ack_ok_o(ack_ok), .ack_to_o(ack_to), .cnt_o(cnt),
        .xsum_o(xsum));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task end_sim();
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk) begin
            addr = a;
            wdata = d;
            wr = 1'b1;
        end
        @(negedge clk) wr = 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk) addr = a;
        @(negedge clk) check("register", rdata, exp);
    endtask : rd_reg

    // load a packet and start it; only called while idle
    task send(input logic [7:0] c, input logic [2:0] sop, input logic [5:0] n);
        logic [7:0] b;
        ctl = c;
        tx_sop = sop;
        exp_n = n;
        exp_x = 8'h00;
        wr_reg(`PDTAC_A_CTL, c);
        wr_reg(`PDTAC_A_LEN, {2'h0, n});
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            exp_x ^= b;
            wr_reg(c[1] ? `PDTAC_A_QUEUE : `PDTAC_A_QUEUE + 16'(i), b);
        end
        wr_reg(`PDTAC_A_CTLB, 8'h01);
    endtask : send

    task wait_q();
        for (int i = 0; i < 400 && expq.size() != 0; i++) @(negedge clk);
        check("pending outcomes", 8'(expq.size()), 8'h00);
        repeat (3) @(negedge clk);
    endtask : wait_q

    // fire one cause: 0 hard reset, 1 cable reset, 2 receive, 3 software,
    // 4 to 6 a receive marked duplicate, ping or acknowledge, which must not abort
    task fire(input int k, input logic [2:0] s);
        if (k == 3) wr_reg(`PDTAC_A_CTLB, 8'h02);
        else begin
            @(negedge clk) begin
                hard = (k == 0);
                cable = (k == 1);
                rx_good = (k == 2) || (k > 3);
                rx_dup = (k == 4);
                rx_ping = (k == 5);
                rx_gcrc = (k == 6);
                rx_sop = s;
            end
            @(negedge clk) {hard, cable, rx_good, rx_dup, rx_ping, rx_gcrc} = 6'h00;
        end
    endtask : fire

    task resp(input logic sr, input logic bi);
        @(negedge clk) {gcrc, gsr, bist} = {~bi, sr, bi};
        @(negedge clk) {gcrc, gsr, bist} = 3'h0;
    endtask : resp

    // outcome watcher: every pulse must match the oldest note
    always @(negedge clk) begin
        ev = {rb, rd_, rs, fail, abrt, done};
        if (!rst && ev !== 6'h00) begin
            check("outcome", 8'(ev), expq.size() ? 8'(expq.pop_front()) : 8'h00);
        end
        if (!rst && (done || abrt || fail)) check("active", 8'(txa), 8'h00);
        if (!rst && pv && pl && pr) check("crc mark", 8'(pc), {7'h00, ~ctl[0]});
    end

    // case table: control, tx type, cause, rx type, aborts at once
    logic [7:0] t_c[11] = '{8'h08, 8'h08, 8'h28, 8'h08, 8'h08, 8'h4c, 8'h08, 8'h08,
        8'h08, 8'h08, 8'h08};
    logic [2:0] t_s[11] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h3, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h3};
    int t_k[11] = '{2, 2, 2, 0, 1, 3, 2, 4, 5, 6, 1};
    logic [2:0] t_r[11] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h1, 3'h0};
    logic t_a[11] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    initial begin
        {rst, wr, busy, rx_good, hard, cable, gcrc, gsr, bist, ack_en} = 10'h200;
        {addr, wdata, rx_sop, tx_sop, ctl, cyc, rx_dup, rx_ping, rx_gcrc} = '0;
        cable_en = 1'b1;
        seed = 67622;
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        rd_reg(`PDTAC_A_CTL, 8'h00);
        rd_reg(`PDTAC_A_PARC, 8'h00);
        rd_reg(16'h1a10, 8'h00);
        wr_reg(`PDTAC_A_CTL, 8'hff);
        rd_reg(`PDTAC_A_CTL, 8'h7f);
        wr_reg(`PDTAC_A_LEN, 8'hff);
        rd_reg(`PDTAC_A_LEN, 8'h3f);
        wr_reg(`PDTAC_A_PARC, 8'h23);
        rd_reg(`PDTAC_A_PARC, 8'h20);
        // quiet line, every queue and data mode, then with acknowledge
        for (int m = 0; m < 5; m++) begin
            ack_en = (m == 4);
            expq.push_back(6'h01);
            send(m == 4 ? 8'h04 : 8'(m), 3'h0, 6'(3 + m));
            wait_q();
            check("frame length", 8'(cnt), 8'(exp_n));
            check("frame data", xsum, exp_x);
        end
        busy = 1'b1;
        expq.push_back(6'h02);
        send(8'h00, 3'h0, 6'h02);
        wait_q();
        expq.push_back(6'h04);
        send(8'h44, 3'h0, 6'h02);
        wait_q();
        send(8'h0c, 3'h0, 6'h02);
        repeat (6) @(negedge clk);
        check("active", 8'(txa), 8'h01);
        expq.push_back(6'h01);
        busy = 1'b0;
        wait_q();
        // silent partner: every attempt times out until the retry limit runs out
        ack_en = 1'b0;
        expq.push_back(6'h04);
        send(8'h04, 3'h0, 6'h02);
        wait_q();
        rd_reg(`PDTAC_A_STAT, 8'h20);
        busy = 1'b1;
        for (int i = 0; i < 11; i++) begin
            cable_en = t_a[i];
            send(t_c[i], t_s[i], 6'h02);
            repeat (4) @(negedge clk);
            if (t_a[i]) expq.push_back(6'h02);
            fire(t_k[i], t_r[i]);
            repeat (5) @(negedge clk);
            if (!t_a[i]) begin
                expq.push_back(6'h02);
                fire(0, 3'h0);
            end
            wait_q();
        end
        // automatic acknowledges: off, idle, busy drop, special, governed by hold
        wr_reg(`PDTAC_A_CTL, 8'h00);
        resp(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        busy = 1'b0;
        wr_reg(`PDTAC_A_CTL, 8'h04);
        expq.push_back(6'h08);
        resp(1'b0, 1'b0);
        expq.push_back(6'h28);
        resp(1'b0, 1'b1);
        wait_q();
        busy = 1'b1;
        expq.push_back(6'h10);
        resp(1'b0, 1'b0);
        wait_q();
        for (int j = 0; j < 2; j++) begin
            wr_reg(`PDTAC_A_CTL, j ? 8'h1c : 8'h04);
            resp(1'b1, 1'b0);
            repeat (5) @(negedge clk);
            expq.push_back(6'h08);
            busy = 1'b0;
            wait_q();
            busy = 1'b1;
        end
        // special case disabled and no hold: the soft reset answer drops like any other
        wr_reg(`PDTAC_A_CTL, 8'h14);
        expq.push_back(6'h10);
        resp(1'b1, 1'b0);
        wait_q();
        end_sim();
    end
endmodule : pdtac_top_test
